// ---- fdh_params.svh ----
// Constants and behaviour summary for the direct FIFO host port
// Behaviour
// - With the FIFO select high on a read, upper address bits are not decoded and every read beat returns receive FIFO data.
// - A direct receive FIFO burst accepts any number of back-to-back read beats.
// - A burst read starts when chip select and read strobe are both low and ends when either goes high, in any order.
// - A 16-bit burst read leaves the upper sixteen data lanes undriven, and an ordinary one may run to sixteen beats instead of eight.
// - Direct receive FIFO reads still decode address bits two and one and ignore bits seven to three.
// - Direct bursts use the ordinary burst handshake and the FIFO select is sampled like an address line.
// - Every write uses the single write protocol at 16-bit or 32-bit width.
// - A write starts when chip select and write strobe are both low and ends when either rises, in any order.
// - A 16-bit write ignores the upper sixteen data lanes and takes only the lower half.
// - With the FIFO select high on a write, upper address bits are not decoded and each write goes to the transmit FIFO.
// - Direct transmit FIFO writes still use address bits two and one and ignore bits seven to three.
// - Ordinary bursts are limited to eight word beats at 32 bits or sixteen at 16 bits.
// - Register reads latch counter values at the start of the cycle so the answer stays stable.
`ifndef FDH_PARAMS_SVH
`define FDH_PARAMS_SVH
`define FDH_ADDR_W       8
`define FDH_DATA_W       32
`define FDH_HALF_W       16
`define FDH_SUB_HI       2
`define FDH_SUB_LO       1
`define FDH_REG_HI       7
`define FDH_REG_LO       3
`define FDH_RXFIFO_REG   5'h00
`define FDH_TXFIFO_REG   5'h04
`define FDH_BURST_MAX32  5'h08
`define FDH_BURST_MAX16  5'h10
`define FDH_BEAT_W       5
`define FDH_BEAT_ONE     5'h01
`endif

// ---- fdh_pkg.sv ----
// Types for the direct FIFO host port
`include "fdh_params.svh"
package fdh_pkg;
	typedef enum logic [1:0] {
		FDH_IDLE,
		FDH_READ,
		FDH_WRITE,
		FDH_WAIT
	} fdh_state_t;

	typedef struct packed {
		logic                       chip_sel_n;
		logic                       read_strobe_n;
		logic                       write_strobe_n;
		logic                       fifo_sel;
		logic [`FDH_ADDR_W-1:1]     addr;
		logic [`FDH_DATA_W-1:0]     wdata;
	} fdh_pins_t;

	typedef struct packed {
		logic                       fifo;
		logic [`FDH_REG_HI:`FDH_SUB_LO] addr;
	} fdh_sel_t;
endpackage

// ---- fdh_host_port.sv ----
// Host bus slave port with direct receive and transmit FIFO access
`timescale 1ns/1ps
`default_nettype none
`include "fdh_params.svh"
module fdh_host_port (
	// Clock and reset
	input  wire logic                   mclk,
	input  wire logic                   reset,
	// Host pins
	input  wire logic                   chip_sel_n,
	input  wire logic                   read_strobe_n,
	input  wire logic                   write_strobe_n,
	input  wire logic                   fifo_sel,
	input  wire logic [`FDH_ADDR_W-1:1] addr,
	input  wire logic [`FDH_DATA_W-1:0] data_in,
	output logic      [`FDH_DATA_W-1:0] data_out,
	output logic      [1:0]             data_oe,
	// Bus width strap, high for 32-bit
	input  wire logic                   bus32,
	// Receive FIFO read side
	input  wire logic [`FDH_DATA_W-1:0] rx_data,
	output logic                        rx_pop,
	output logic      [1:0]             rx_sub,
	// Transmit FIFO write side
	output logic                        tx_push,
	output logic      [`FDH_DATA_W-1:0] tx_data,
	output logic      [1:0]             tx_sub,
	// Register map access
	output logic                        reg_rd,
	output logic                        reg_latch,
	output logic                        reg_wr,
	output logic      [`FDH_REG_HI:`FDH_SUB_LO] reg_addr,
	output logic      [`FDH_DATA_W-1:0] reg_wdata,
	input  wire logic [`FDH_DATA_W-1:0] reg_rdata,
	// Ordinary burst overrun seen
	output logic                        burst_over
);
	fdh_pkg::fdh_pins_t     s1_q;
	fdh_pkg::fdh_pins_t     s2_q;
	fdh_pkg::fdh_state_t    st_q;
	fdh_pkg::fdh_state_t    st_d;
	fdh_pkg::fdh_sel_t      sel_q;
	fdh_pkg::fdh_sel_t      sel_d;
	logic [`FDH_BEAT_W-1:0] beats_q;
	logic [`FDH_BEAT_W-1:0] beats_d;
	logic [`FDH_DATA_W-1:0] dout_q;
	logic [`FDH_DATA_W-1:0] dout_d;
	logic [`FDH_DATA_W-1:0] txd_q;
	logic [`FDH_DATA_W-1:0] txd_d;
	logic [`FDH_DATA_W-1:0] rwd_q;
	logic [`FDH_DATA_W-1:0] rwd_d;
	logic [1:0]             oe_q;
	logic [1:0]             oe_d;
	logic                   pop_q;
	logic                   pop_d;
	logic                   push_q;
	logic                   push_d;
	logic                   rrd_q;
	logic                   rrd_d;
	logic                   lat_q;
	logic                   lat_d;
	logic                   rwr_q;
	logic                   rwr_d;
	logic                   ovr_q;
	logic                   ovr_d;
	logic                   rd_act;
	logic                   wr_act;
	logic                   bus32_m_q;
	logic                   bus32_q;

	// Direct mode ignores upper bits; only the sub-word select remains
	function automatic fdh_pkg::fdh_sel_t decode(input logic fs, input logic [`FDH_ADDR_W-1:1] a);
		fdh_pkg::fdh_sel_t r;
		r.fifo = fs;
		r.addr = fs ? {5'h00, a[`FDH_SUB_HI:`FDH_SUB_LO]} : a[`FDH_REG_HI:`FDH_SUB_LO];
		return r;
	endfunction

	function automatic logic [`FDH_DATA_W-1:0] lanes(input logic w32, input logic [`FDH_DATA_W-1:0] d);
		return w32 ? d : {{`FDH_HALF_W{1'b0}}, d[`FDH_HALF_W-1:0]};
	endfunction

	// Pins pass two flops before use
	// Width strap is a pin too, so it takes the same two flops
	always_ff @(posedge mclk) begin
		if (reset) begin
			s1_q <= '1;
			s2_q <= '1;
			bus32_m_q <= 1'b1;
			bus32_q <= 1'b1;
		end else begin
			s1_q <= {chip_sel_n, read_strobe_n, write_strobe_n, fifo_sel, addr, data_in};
			s2_q <= s1_q;
			bus32_m_q <= bus32;
			bus32_q <= bus32_m_q;
		end
	end

	assign rd_act = !s2_q.chip_sel_n && !s2_q.read_strobe_n;
	assign wr_act = !s2_q.chip_sel_n && !s2_q.write_strobe_n;

	always_comb begin
		st_d = st_q;
		sel_d = sel_q;
		beats_d = beats_q;
		dout_d = dout_q;
		txd_d = txd_q;
		rwd_d = rwd_q;
		oe_d = 2'b00;
		pop_d = 1'b0;
		push_d = 1'b0;
		rrd_d = 1'b0;
		lat_d = 1'b0;
		rwr_d = 1'b0;
		ovr_d = ovr_q;
		unique case (st_q)
			fdh_pkg::FDH_IDLE: begin
				// Limit flag lives only as long as the offending burst
				ovr_d = 1'b0;
				if (rd_act) begin
					st_d = fdh_pkg::FDH_READ;
					sel_d = decode(s2_q.fifo_sel, s2_q.addr);
					beats_d = `FDH_BEAT_ONE;
					lat_d = !s2_q.fifo_sel;
					pop_d = s2_q.fifo_sel;
					rrd_d = !s2_q.fifo_sel;
				end else if (wr_act) begin
					st_d = fdh_pkg::FDH_WRITE;
					sel_d = decode(s2_q.fifo_sel, s2_q.addr);
				end
			end
			fdh_pkg::FDH_READ: begin
				oe_d = bus32_q ? 2'b11 : 2'b01;
				// Follows its source each cycle, so a new FIFO head shows at once
				dout_d = lanes(bus32_q, sel_q.fifo ? rx_data : reg_rdata);
				if (!rd_act) begin
					st_d = fdh_pkg::FDH_IDLE;
					oe_d = 2'b00;
				end else if (decode(s2_q.fifo_sel, s2_q.addr) != sel_q) begin
					// New address within the burst is a new beat
					sel_d = decode(s2_q.fifo_sel, s2_q.addr);
					pop_d = sel_d.fifo;
					rrd_d = !sel_d.fifo;
					// Counter stops at the limit, so a long burst cannot wrap it
					if (!sel_d.fifo) begin
						if (beats_q >= (bus32_q ? `FDH_BURST_MAX32 : `FDH_BURST_MAX16)) begin
							ovr_d = 1'b1;
							rrd_d = 1'b0;
						end else begin
							beats_d = beats_q + `FDH_BEAT_ONE;
						end
					end
				end
			end
			fdh_pkg::FDH_WRITE: begin
				// Data sampled continuously; last value before release wins
				txd_d = lanes(bus32_q, s2_q.wdata);
				rwd_d = lanes(bus32_q, s2_q.wdata);
				if (!wr_act) begin
					st_d = fdh_pkg::FDH_IDLE;
					push_d = sel_q.fifo;
					rwr_d = !sel_q.fifo;
					// Keep the word from before release; the bus may already move on
					txd_d = txd_q;
					rwd_d = rwd_q;
				end
			end
			default: begin
				// Spare state code is never entered; fall back to idle
				st_d = fdh_pkg::FDH_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			st_q <= fdh_pkg::FDH_IDLE;
			sel_q <= '0;
			beats_q <= '0;
			dout_q <= '0;
			txd_q <= '0;
			rwd_q <= '0;
			oe_q <= 2'b00;
			pop_q <= 1'b0;
			push_q <= 1'b0;
			rrd_q <= 1'b0;
			lat_q <= 1'b0;
			rwr_q <= 1'b0;
			ovr_q <= 1'b0;
		end else begin
			st_q <= st_d;
			sel_q <= sel_d;
			beats_q <= beats_d;
			dout_q <= dout_d;
			txd_q <= txd_d;
			rwd_q <= rwd_d;
			oe_q <= oe_d;
			pop_q <= pop_d;
			push_q <= push_d;
			rrd_q <= rrd_d;
			lat_q <= lat_d;
			rwr_q <= rwr_d;
			ovr_q <= ovr_d;
		end
	end

	// Every output is a register; nothing combinational reaches a pin
	assign data_out = dout_q;
	assign data_oe = oe_q;
	assign rx_pop = pop_q;
	assign rx_sub = sel_q.addr[`FDH_SUB_HI:`FDH_SUB_LO];
	assign tx_push = push_q;
	assign tx_data = txd_q;
	assign tx_sub = sel_q.addr[`FDH_SUB_HI:`FDH_SUB_LO];
	assign reg_rd = rrd_q;
	assign reg_latch = lat_q;
	assign reg_wr = rwr_q;
	assign reg_addr = sel_q.addr;
	assign reg_wdata = rwd_q;
	assign burst_over = ovr_q;
endmodule
`default_nettype wire

// ---- fdh_host_port_properties.sv ----
// Port timing checks for the direct FIFO host port
`timescale 1ns/1ps
`default_nettype none
module fdh_port_props (
	// Clock, reset and host pins
	input wire logic        mclk, reset, chip_sel_n, read_strobe_n, write_strobe_n, fifo_sel, bus32,
	// Internal side
	input wire logic        rx_pop, tx_push, reg_rd, reg_latch, reg_wr,
	input wire logic [1:0]  data_oe,
	input wire logic [31:0] tx_data
);
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	sequence s_rd_go;
		$fell(chip_sel_n | read_strobe_n) && write_strobe_n;
	endsequence
	sequence s_wr_end;
		$rose(chip_sel_n | write_strobe_n) && read_strobe_n && $past(fifo_sel);
	endsequence
	AST_DRD_POP: assert property (s_rd_go ##0 fifo_sel |-> ##[2:4] rx_pop) else $error("no pop");
	AST_ORD_LATCH: assert property (s_rd_go ##0 !fifo_sel |-> ##[2:4] reg_latch) else $error("no latch");
	AST_POP_NOREG: assert property (rx_pop |-> !reg_rd && !reg_latch) else $error("pop with reg");
	AST_DRD_NOREG: assert property ((fifo_sel && !chip_sel_n && !read_strobe_n)[*4] |-> !reg_rd) else $error("reg rd");
	AST_OE16: assert property (!bus32 && $past(bus32, 3) == 1'b0 |-> !data_oe[1]) else $error("upper lanes");
	AST_OE_OFF: assert property ((chip_sel_n | read_strobe_n)[*4] |-> data_oe == 2'b00) else $error("oe stuck");
	AST_WR_PUSH: assert property (s_wr_end |-> ##[2:4] tx_push && !reg_wr) else $error("no push");
	AST_TX16: assert property (tx_push && !bus32 |-> tx_data[31:16] == 16'h0000) else $error("upper data");
	AST_PUSH_ONE: assert property (tx_push |=> !tx_push && !reg_wr) else $error("double push");
endmodule
bind fdh_host_port fdh_port_props u_props (.mclk, .reset, .chip_sel_n, .read_strobe_n, .write_strobe_n, .fifo_sel,
	.bus32, .rx_pop, .tx_push, .reg_rd, .reg_latch, .reg_wr, .data_oe, .tx_data);
`default_nettype wire

// ---- fdh_host_model.sv ----
// Host bus master driving the port pins
`timescale 1ns/1ps
`default_nettype none
module fdh_host_model (
	input  wire logic  mclk,
	output logic       chip_sel_n, read_strobe_n, write_strobe_n, fifo_sel,
	output logic [7:1] addr,
	output logic [31:0] data_in
);
	initial begin
		{chip_sel_n, read_strobe_n, write_strobe_n, fifo_sel} = 4'he;
		addr = 7'h00;
		data_in = 32'h0000_0000;
	end
	// Beats change address; upper bits move too, so decoding them would show
	task automatic rd(input logic fs, input int n);
		@(negedge mclk);
		fifo_sel = fs;
		chip_sel_n = 1'b0;
		read_strobe_n = 1'b0;
		for (int k = 0; k < n; k++) begin
			addr = {5'(k * 3), 2'(k)};
			repeat (3) @(negedge mclk);
		end
		chip_sel_n = 1'b1;
		repeat (5) @(negedge mclk);
		read_strobe_n = 1'b1;
	endtask
	task automatic wr(input logic fs, input logic [7:1] a, input logic [31:0] d);
		@(negedge mclk);
		fifo_sel = fs;
		addr = a;
		data_in = d;
		chip_sel_n = 1'b0;
		write_strobe_n = 1'b0;
		repeat (3) @(negedge mclk);
		write_strobe_n = 1'b1;
		data_in = ~d;
		repeat (5) @(negedge mclk);
	endtask
endmodule
`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench for the direct FIFO host port
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        mclk = 1'b0, reset = 1'b1, bus32 = 1'b1;
	logic        chip_sel_n, read_strobe_n, write_strobe_n, fifo_sel;
	logic        rx_pop, tx_push, reg_rd, reg_latch, reg_wr, burst_over;
	logic [7:1]  addr, reg_addr;
	logic [31:0] data_in, data_out, tx_data, reg_wdata, rx_head = 32'h0000_0000;
	logic [1:0]  data_oe, rx_sub, tx_sub, oe_seen;
	int          num_errors = 0, compares = 0, n_pop, n_rd, n_latch, n_push, n_wr, n_over;
	always #25 mclk = ~mclk;
	always @(posedge mclk) begin
		rx_head <= rx_head + 32'(rx_pop === 1'b1);
		n_pop <= n_pop + int'(rx_pop);
		n_rd <= n_rd + int'(reg_rd);
		n_latch <= n_latch + int'(reg_latch);
		n_push <= n_push + int'(tx_push);
		n_wr <= n_wr + int'(reg_wr);
		n_over <= n_over + int'(burst_over);
		oe_seen <= oe_seen | data_oe;
	end
	fdh_host_model host (.mclk, .chip_sel_n, .read_strobe_n, .write_strobe_n, .fifo_sel, .addr, .data_in);
	fdh_host_port dut (.mclk, .reset, .chip_sel_n, .read_strobe_n, .write_strobe_n, .fifo_sel, .addr, .data_in,
		.data_out, .data_oe, .bus32, .rx_data(rx_head), .rx_pop, .rx_sub, .tx_push, .tx_data, .tx_sub, .reg_rd,
		.reg_latch, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata(32'h0f0f_0f0f), .burst_over);
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %0t seen %h want %h", $time, seen, exp);
		end
	endtask
	task automatic restart(input logic b);
		@(negedge mclk);
		bus32 = b;
		reset = 1'b1;
		{n_pop, n_rd, n_latch, n_push, n_wr, n_over, oe_seen} = '0;
		repeat (8) @(negedge mclk);
		reset = 1'b0;
	endtask
	task automatic give_verdict();
		$display("checks %0d errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic t_bursts();
		host.rd(1'b1, 10);
		check(n_pop, 10);
		check(data_out, rx_head);
		check(n_rd + n_latch, 0);
		check(rx_sub, 2'h1);
		check(oe_seen, 2'h3);
		check(n_over, 0);
		host.rd(1'b0, 9);
		check(n_rd, 8);
		check(n_over != 0, 1);
		check(n_latch, 1);
		check(n_pop, 10);
		check(data_out, 32'h0f0f_0f0f);
		$display("bursts done");
	endtask
	task automatic t_writes();
		host.wr(1'b0, 7'h12, 32'hcafe_f00d);
		check(n_wr, 1);
		check(reg_wdata, 32'hcafe_f00d);
		check(reg_addr, 7'h12);
		host.wr(1'b1, 7'h7d, 32'h1357_9bdf);
		check(n_push, 1);
		check(tx_data, 32'h1357_9bdf);
		check(tx_sub, 2'h1);
		check(n_wr, 1);
		$display("writes done");
	endtask
	task automatic t_half();
		host.rd(1'b1, 3);
		check(n_pop, 3);
		check(oe_seen, 2'h1);
		check(rx_sub, 2'h2);
		check(data_out, {16'h0000, rx_head[15:0]});
		host.wr(1'b1, 7'h36, 32'hdead_beef);
		check(tx_data, 32'h0000_beef);
		check(tx_sub, 2'h2);
		$display("half width done");
	endtask
	initial begin
		restart(1'b1);
		t_bursts();
		t_writes();
		restart(1'b0);
		t_half();
		give_verdict();
	end
	// Whole run is about 130 cycles
	initial begin
		repeat (3000) @(posedge mclk);
		num_errors++;
		give_verdict();
	end
endmodule
`default_nettype wire
